// ---- hdl/tsw_pkg.sv ----
// package: constants and types of the time-slot switch control port
package tsw_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ = 250000;
   localparam int BIT_KHZ = 2048;
   localparam int ACC_W = 18;
   localparam logic [17:0] ACC_STEP = 18'(BIT_KHZ);
   localparam logic [17:0] ACC_WRAP = 18'(CLK_KHZ);
   // ------------------------------------------------------------
   // frame geometry
   // ------------------------------------------------------------
   localparam int STREAMS = 8;
   localparam int CHANS = 32;
   localparam int BUFS = 3;
   localparam logic [4:0] LAST_CHAN = 5'h1f;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [4:0] VAR_MIN_GAP = 5'h03;
   // ------------------------------------------------------------
   // host address decode and control register
   // ------------------------------------------------------------
   localparam int ADDR_CHAN_BIT = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_RD_MASK = 8'hdf;
   localparam logic [1:0] MS_DATA = 2'h1;
   localparam logic [1:0] MS_CML = 2'h2;
   localparam logic [1:0] MS_CMH = 2'h3;
   // ------------------------------------------------------------
   // high connection memory fields
   // ------------------------------------------------------------
   localparam int CMH_OE_BIT = 0;
   localparam int CMH_CCO_BIT = 1;
   localparam int CMH_SRC_BIT = 2;
   localparam int CMH_CONST_BIT = 6;

   typedef struct packed {
      logic split_access_bit;
      logic host_source_all_bit;
      logic spare;
      logic [1:0] memory_select_field;
      logic [2:0] stream_select_field;
   } tsw_ctrl_t;

   typedef struct packed {
      logic cs_n;
      logic ds;
      logic rw;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tsw_host_req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic data_oe;
      logic dta_n;
   } tsw_host_rsp_t;
endpackage

// ---- hdl/tsw_switch_ctrl.sv ----
// top: host port, control register, connection memories and serial output control
//
// How it works
// R1: address bits 5,1,0 low reach the control register; bits 4-2 ignored.
// R2: address bit 5 high selects one of 32 channels in chosen memory and stream.
// R3: control bits 2-0 pick the stream subsection reached by a channel access.
// R4: split bit 7 set: reads from data memory, writes to low connection memory.
// R5: memory select 01 data (read only), 10 low, 11 high; 00 not used.
// R6: source-all bit 6 forces channel-source and output-enable high for every channel.
// R7: otherwise high bit 2 set sends low byte, clear uses it as source address.
// R8: master drive low holds every serial output stream in high impedance.
// R9: master drive high: high memory bit 0 enables each channel's driver.
// R10: control-bit output, 256 bits a frame, each the high memory bit 1.
// R11: control bits go one channel early; stream 0 channel 0 with channel 31 bit 7.
// R12: control bits of streams 0-7 follow in order over bit times 7 to 0.
// R13: reset floats all streams and clears registers and counters.
// R14: master drive touches only output enables, never registers or memories.
// R15: host programs connections and disables the rest before raising master drive.
// R16: variable delay: gap of three or more slots kept, closer pairs go next frame.
// R17: constant delay: byte received in frame N leaves in frame N+2.
// R18: high memory bit 6 picks variable (low) or constant (high) delay.
`timescale 1ns/1ns
module tsw_switch_ctrl (
   input wire logic ref_clk, // 250 MHz clock
   input wire logic resetn, // async reset, active low
   input wire tsw_pkg::tsw_host_req_t host_req, // host port pins
   output tsw_pkg::tsw_host_rsp_t host_rsp, // host data out, enable, acknowledge
   input wire logic [7:0] rx_in, // serial input streams
   input wire logic master_drive_in, // master output drive enable
   output logic [7:0] serial_out_streams, // serial output data
   output logic [7:0] serial_out_oe, // serial output drive enables
   output logic per_channel_ctrl_out // control-bit serial output
);
   // ------------------------------------------------------------
   // memories and state
   // ------------------------------------------------------------
   logic [7:0] dm [tsw_pkg::BUFS][256];
   logic [7:0] conn_mem_low [256];
   logic [7:0] conn_mem_high [256];

   tsw_pkg::tsw_host_req_t host_s1_q, host_s2_q;
   logic [7:0] rx_s1_q, rx_s2_q;
   logic drv_s1_q, drv_s2_q;

   tsw_pkg::tsw_ctrl_t ctrl_q, ctrl_d;
   logic busy_q, busy_d;
   tsw_pkg::tsw_host_rsp_t rsp_q, rsp_d;
   logic cml_we, cmh_we;
   logic [7:0] host_idx;

   logic [17:0] acc_q, acc_d;
   logic bit_en;
   logic [2:0] bit_q, bit_d;
   logic [4:0] chan_q, chan_d;
   logic [1:0] wbuf_q, wbuf_d;

   logic [7:0][7:0] rxsh_q, rxsh_d;
   logic [7:0][7:0] txsh_q, txsh_d;
   logic [7:0] chen_q, chen_d;
   logic [7:0] oe_q, oe_d;
   logic cco_q, cco_d;
   logic [7:0][7:0] ld_byte;
   logic [7:0] ld_en;
   logic [4:0] next_chan;
   logic [1:0] tgt_buf;

   function automatic logic [1:0] buf_back(input logic [1:0] b, input logic [1:0] k);
      logic [1:0] r;
      r = b;
      if (k == 2'h1) begin
         r = (b == 2'h0) ? 2'h2 : b - 2'h1;
      end else if (k == 2'h2) begin
         r = (b == 2'h2) ? 2'h0 : b + 2'h1;
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         host_s1_q <= '{cs_n: 1'b1, default: '0};
         host_s2_q <= '{cs_n: 1'b1, default: '0};
         rx_s1_q <= 8'h00;
         rx_s2_q <= 8'h00;
         drv_s1_q <= 1'b0;
         drv_s2_q <= 1'b0;
      end else begin
         host_s1_q <= host_req;
         host_s2_q <= host_s1_q;
         rx_s1_q <= rx_in;
         rx_s2_q <= rx_s1_q;
         drv_s1_q <= master_drive_in;
         drv_s2_q <= drv_s1_q;
      end
   end

   // ------------------------------------------------------------
   // host port and control register
   // ------------------------------------------------------------
   always_comb begin
      logic [1:0] rsel;
      logic [1:0] wsel;
      logic start;
      ctrl_d = ctrl_q;
      busy_d = busy_q;
      rsp_d = rsp_q;
      cml_we = 1'b0;
      cmh_we = 1'b0;
      rsel = ctrl_q.split_access_bit ? tsw_pkg::MS_DATA : ctrl_q.memory_select_field; // R4 R5
      wsel = ctrl_q.split_access_bit ? tsw_pkg::MS_CML : ctrl_q.memory_select_field; // R4 R5
      host_idx = {ctrl_q.stream_select_field, host_s2_q.addr[4:0]}; // R2 R3
      start = !host_s2_q.cs_n && host_s2_q.ds && !busy_q;
      if (start) begin
         busy_d = 1'b1;
         rsp_d.dta_n = 1'b0;
         rsp_d.data_oe = host_s2_q.rw;
         rsp_d.rdata = 8'h00;
         if (host_s2_q.addr[tsw_pkg::ADDR_CHAN_BIT]) begin
            if (host_s2_q.rw) begin
               unique case (rsel)
                  tsw_pkg::MS_DATA: rsp_d.rdata = dm[buf_back(wbuf_q, 2'h1)][host_idx];
                  tsw_pkg::MS_CML: rsp_d.rdata = conn_mem_low[host_idx];
                  tsw_pkg::MS_CMH: rsp_d.rdata = conn_mem_high[host_idx];
                  default: rsp_d.rdata = 8'h00;
               endcase
            end else begin
               cml_we = (wsel == tsw_pkg::MS_CML); // R5
               cmh_we = (wsel == tsw_pkg::MS_CMH); // R5
            end
         end else if (host_s2_q.addr[1:0] == 2'h0) begin
            if (host_s2_q.rw) begin
               rsp_d.rdata = ctrl_q & tsw_pkg::CTRL_RD_MASK; // R1
            end else begin
               ctrl_d = host_s2_q.wdata; // R1
            end
         end
      end else if (busy_q && (host_s2_q.cs_n || !host_s2_q.ds)) begin
         busy_d = 1'b0;
         rsp_d.dta_n = 1'b1;
         rsp_d.data_oe = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= tsw_pkg::CTRL_RESET; // R13
         busy_q <= 1'b0;
         rsp_q <= '{rdata: 8'h00, data_oe: 1'b0, dta_n: 1'b1};
      end else begin
         ctrl_q <= ctrl_d;
         busy_q <= busy_d;
         rsp_q <= rsp_d;
      end
   end

   // ------------------------------------------------------------
   // bit, channel and frame timing
   // ------------------------------------------------------------
   always_comb begin
      logic [17:0] sum;
      sum = acc_q + tsw_pkg::ACC_STEP;
      bit_en = (sum >= tsw_pkg::ACC_WRAP);
      acc_d = bit_en ? sum - tsw_pkg::ACC_WRAP : sum;
      bit_d = bit_q;
      chan_d = chan_q;
      wbuf_d = wbuf_q;
      if (bit_en) begin
         bit_d = bit_q + 3'h1;
         if (bit_q == tsw_pkg::LAST_BIT) begin
            chan_d = chan_q + 5'h01;
            if (chan_q == tsw_pkg::LAST_CHAN) begin
               wbuf_d = buf_back(wbuf_q, 2'h2);
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         acc_q <= '0; // R13
         bit_q <= 3'h0;
         chan_q <= 5'h00;
         wbuf_q <= 2'h0;
      end else begin
         acc_q <= acc_d;
         bit_q <= bit_d;
         chan_q <= chan_d;
         wbuf_q <= wbuf_d;
      end
   end

   // ------------------------------------------------------------
   // per-stream source selection for the next channel
   // ------------------------------------------------------------
   assign next_chan = chan_q + 5'h01;
   assign tgt_buf = (chan_q == tsw_pkg::LAST_CHAN) ? buf_back(wbuf_q, 2'h2) : wbuf_q;

   for (genvar s = 0; s < tsw_pkg::STREAMS; s++) begin : g_src
      logic [7:0] loc;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [4:0] gap;
      logic [1:0] back;
      assign loc = {3'(s), next_chan};
      assign hi = conn_mem_high[loc];
      assign lo = conn_mem_low[loc];
      assign gap = next_chan - lo[4:0];
      always_comb begin
         back = 2'h2; // R17
         if (!hi[tsw_pkg::CMH_CONST_BIT]) begin // R18
            back = 2'((next_chan < lo[4:0]) ? 1 : 0) + 2'((gap < tsw_pkg::VAR_MIN_GAP) ? 1 : 0); // R16
         end
         if (ctrl_q.host_source_all_bit || hi[tsw_pkg::CMH_SRC_BIT]) begin // R6 R7
            ld_byte[s] = lo;
         end else begin
            ld_byte[s] = dm[buf_back(tgt_buf, back)][lo]; // R7
         end
         ld_en[s] = ctrl_q.host_source_all_bit || hi[tsw_pkg::CMH_OE_BIT]; // R6 R9
      end
   end

   // ------------------------------------------------------------
   // serial shifters, drive enables and control-bit output
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] cloc;
      rxsh_d = rxsh_q;
      txsh_d = txsh_q;
      chen_d = chen_q;
      cco_d = cco_q;
      cloc = {bit_d, chan_d + 5'h01};
      if (bit_en) begin
         for (int s = 0; s < tsw_pkg::STREAMS; s++) begin
            rxsh_d[s] = {rxsh_q[s][6:0], rx_s2_q[s]};
            txsh_d[s] = {txsh_q[s][6:0], 1'b0};
         end
         if (bit_q == tsw_pkg::LAST_BIT) begin
            txsh_d = ld_byte;
            chen_d = ld_en;
         end
         cco_d = conn_mem_high[cloc][tsw_pkg::CMH_CCO_BIT]; // R10 R11 R12
      end
      oe_d = drv_s2_q ? chen_q : 8'h00; // R8 R9 R14
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rxsh_q <= '0;
         txsh_q <= '0;
         chen_q <= 8'h00;
         oe_q <= 8'h00; // R13
         cco_q <= 1'b0;
      end else begin
         rxsh_q <= rxsh_d;
         txsh_q <= txsh_d;
         chen_q <= chen_d;
         oe_q <= oe_d;
         cco_q <= cco_d;
      end
   end

   // ------------------------------------------------------------
   // memory writes (contents are not cleared by reset)
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (cml_we) begin
         conn_mem_low[host_idx] <= host_s2_q.wdata;
      end
      if (cmh_we) begin
         conn_mem_high[host_idx] <= host_s2_q.wdata;
      end
      if (bit_en && bit_q == tsw_pkg::LAST_BIT) begin
         for (int s = 0; s < tsw_pkg::STREAMS; s++) begin
            dm[wbuf_q][{3'(s), chan_q}] <= {rxsh_q[s][6:0], rx_s2_q[s]};
         end
      end
   end

   for (genvar s = 0; s < tsw_pkg::STREAMS; s++) begin : g_out
      assign serial_out_streams[s] = txsh_q[s][7];
   end
   assign serial_out_oe = oe_q;
   assign per_channel_ctrl_out = cco_q;
   assign host_rsp = rsp_q;
endmodule

// ---- tb/tsw_switch_ctrl_asserts.sv ----
// checker: port relations of the switch control block
`timescale 1ns/1ns
module tsw_switch_ctrl_asserts (
   input wire logic ref_clk, // clock
   input wire logic resetn, // reset
   input wire tsw_pkg::tsw_host_req_t host_req, // host pins
   input wire tsw_pkg::tsw_host_rsp_t host_rsp, // host answer
   input wire logic [7:0] rx_in, // serial in
   input wire logic master_drive_in, // master drive
   input wire logic [7:0] serial_out_streams, // serial out
   input wire logic [7:0] serial_out_oe, // enables
   input wire logic per_channel_ctrl_out // control bits
);
   // ----------
   // cycles since a serial bit last moved
   // ----------
   logic [1:0] prev_q;
   logic [7:0] gap_q;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 2'h0;
         gap_q <= 8'hff;
      end else begin
         prev_q <= {per_channel_ctrl_out, serial_out_streams[0]};
         if (prev_q != {per_channel_ctrl_out, serial_out_streams[0]}) begin
            gap_q <= 8'h00;
         end else if (gap_q != 8'hff) begin
            gap_q <= gap_q + 8'h01;
         end
      end
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   chk_reset_float: assert property (disable iff (1'b0) !resetn |-> serial_out_oe == 8'h00)
      else $error("enable set in reset");
   chk_drive_low_float: assert property (!master_drive_in [*3] |=> serial_out_oe == 8'h00)
      else $error("driven with drive low");
   chk_oe_needs_drive: assert property (|serial_out_oe |-> $past(master_drive_in, 3))
      else $error("enable without drive");
   chk_ctrl_bit_hold: assert property (per_channel_ctrl_out != prev_q[1] |-> gap_q >= 8'd121)
      else $error("control bit too short");
   chk_stream_bit_hold: assert property (serial_out_streams[0] != prev_q[0] |-> gap_q >= 8'd121)
      else $error("stream bit too short");
   chk_ack_timely: assert property (host_req.ds && !host_req.cs_n && host_rsp.dta_n
      |-> ##[1:5] !host_rsp.dta_n) else $error("late acknowledge");
   chk_ctrl_bit5_low: assert property (host_req.ds && host_req.rw && !host_req.addr[5]
      && host_req.addr[1:0] == 2'h0 && !host_rsp.dta_n |-> !host_rsp.rdata[5])
      else $error("spare bit read high");
   chk_unmapped_zero: assert property (host_req.ds && host_req.rw && !host_req.addr[5]
      && host_req.addr[1:0] != 2'h0 && !host_rsp.dta_n |-> host_rsp.rdata == 8'h00)
      else $error("unmapped read nonzero");
endmodule

// ---- tb/tsw_host_model.sv ----
// host processor model: one access per strobe, held until acknowledged
`timescale 1ns/1ns
module tsw_host_model (
   input wire logic ref_clk, // clock
   output tsw_pkg::tsw_host_req_t host_req, // pins to switch
   input wire tsw_pkg::tsw_host_rsp_t host_rsp // answer
);
   initial host_req = '{1'b1, 1'b0, 1'b0, 6'h00, 8'h00};
   // ----------
   // bus cycle; released pins show the inverse of the last value
   // ----------
   task automatic acc(input logic rd, input logic [5:0] a, input logic [7:0] wd,
      output logic [7:0] rv);
      int n;
      n = 0;
      @(negedge ref_clk);
      host_req <= '{1'b0, 1'b1, rd, a, wd};
      do begin
         @(posedge ref_clk);
         n++;
      end while (host_rsp.dta_n !== 1'b0 && n < 50);
      // a missing acknowledge hands back unknown data so the caller flags it
      rv = (host_rsp.dta_n === 1'b0) ? host_rsp.rdata : 8'hxx;
      @(negedge ref_clk);
      host_req <= '{1'b1, 1'b0, ~rd, ~a, ~wd};
      while (host_rsp.dta_n !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (3) @(posedge ref_clk);
   endtask
endmodule

// ---- tb/tb_tsw_switch_ctrl.sv ----
// testbench: host access, control-bit timing and master drive
`timescale 1ns/1ns
module tb_tsw_switch_ctrl;
   logic ref_clk = 1'b0;
   logic resetn = 1'b1;
   logic [7:0] rx_in = 8'h00;
   logic master_drive_in = 1'b0;
   tsw_pkg::tsw_host_req_t host_req;
   tsw_pkg::tsw_host_rsp_t host_rsp;
   logic [7:0] serial_out_streams;
   logic [7:0] serial_out_oe;
   logic per_channel_ctrl_out;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   integer seed = 32'h59c3;
   logic [7:0] v;
   logic [7:0] d;
   logic [4:0] c;
   logic [2:0] s;
   always #2 ref_clk = ~ref_clk;
   tsw_switch_ctrl i_tsw_switch_ctrl (.ref_clk, .resetn, .host_req, .host_rsp, .rx_in,
      .master_drive_in, .serial_out_streams, .serial_out_oe, .per_channel_ctrl_out);
   tsw_host_model i_tsw_host_model (.ref_clk, .host_req, .host_rsp);
   // ----------
   // shared tasks
   // ----------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] wd);
      logic [7:0] r;
      i_tsw_host_model.acc(1'b0, a, wd, r);
      if (r === 8'hxx) chk(r, wd);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] r;
      i_tsw_host_model.acc(1'b1, a, 8'h00, r);
      chk(r, exp);
   endtask
   task automatic sel(input logic pe, input logic [1:0] ms, input logic [2:0] st);
      wr(6'h00, {1'b0, pe, 1'b0, ms, st});
   endtask
   function automatic logic [7:0] bit_fill(input logic b);
      return {8{b}};
   endfunction
   // waits for the lone control bit, then samples extra cycles past mid-bit
   task automatic cco_hit(input int extra, input logic [2:0] exp);
      int n;
      n = 0;
      while (per_channel_ctrl_out !== 1'b0 && n < 40000) begin
         @(negedge ref_clk);
         n++;
      end
      while (per_channel_ctrl_out !== 1'b1 && n < 40000) begin
         @(negedge ref_clk);
         n++;
      end
      repeat (60 + extra) @(negedge ref_clk);
      chk({5'h00, per_channel_ctrl_out, serial_out_streams[0], serial_out_oe[0]}, {5'h00, exp});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   initial begin
      // reset falls off the clock edge so every flop is cleared before the first edge
      #1 resetn = 1'b0;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      rx_in = 8'($random(seed));
      resetn = 1'b1;
      rd(6'h00, tsw_pkg::CTRL_RESET);
      for (int i = 0; i < 3; i++) begin
         v = 8'($random(seed));
         s = 3'($random(seed));
         v[4:3] = (v[4:3] == 2'h0) ? tsw_pkg::MS_CMH : v[4:3];
         wr({1'b0, s, 2'h0}, v);
         rd({1'b0, ~s, 2'h0}, v & tsw_pkg::CTRL_RD_MASK);
      end
      rd(6'h03, 8'h00);
      $display("control register test end");
      for (int i = 0; i < 9; i++) begin
         sel(1'b0, (i < 8) ? tsw_pkg::MS_CMH : tsw_pkg::MS_CML, i[2:0]);
         for (int j = 0; j < 32; j++) begin
            wr({1'b1, j[4:0]}, 8'h00);
         end
      end
      s = 3'($random(seed)) | 3'h1;
      c = 5'($random(seed));
      d = 8'($random(seed));
      v = 8'($random(seed)) & 8'h45;
      sel(1'b0, tsw_pkg::MS_CMH, s);
      wr({1'b1, c}, v);
      rd({1'b1, c}, v);
      sel(1'b0, tsw_pkg::MS_CML, s);
      wr({1'b1, c}, d);
      wr(6'h00, {3'h4, tsw_pkg::MS_CML, s});
      wr({1'b1, c}, ~d);
      sel(1'b0, tsw_pkg::MS_DATA, s);
      wr({1'b1, c}, d);
      sel(1'b0, tsw_pkg::MS_CML, s);
      rd({1'b1, c}, ~d);
      $display("memory access test end");
      @(negedge ref_clk);
      master_drive_in = 1'b1;
      sel(1'b1, tsw_pkg::MS_CML, 3'h0);
      wr(6'h3f, 8'h80);
      sel(1'b1, tsw_pkg::MS_CMH, 3'h0);
      wr(6'h20, 8'h02);
      cco_hit(0, 3'h7);
      wr(6'h20, 8'h00);
      s = 3'($random(seed));
      sel(1'b1, tsw_pkg::MS_CMH, s);
      wr(6'h21, 8'h02);
      sel(1'b1, tsw_pkg::MS_CML, 3'h0);
      wr(6'h3f, 8'h00);
      wr(6'h20, 8'h80 >> s);
      cco_hit(0, 3'h7);
      @(negedge ref_clk);
      master_drive_in = 1'b0;
      repeat (5) @(negedge ref_clk);
      chk(serial_out_oe, 8'h00);
      rd(6'h20, 8'h80 >> s);
      sel(1'b0, tsw_pkg::MS_CMH, s);
      wr(6'h21, 8'h00);
      s = 3'($random(seed));
      sel(1'b1, tsw_pkg::MS_DATA, s);
      rd(6'h2a, bit_fill(rx_in[s]));
      wr(6'h00, {3'h4, tsw_pkg::MS_CMH, s});
      rd(6'h2a, bit_fill(rx_in[s]));
      $display("serial output test end");
      // stream 0 channel c takes its byte from data memory, variable delay
      d = 8'($random(seed));
      c = 5'($random(seed)) | 5'h08;
      sel(1'b0, tsw_pkg::MS_CML, 3'h0);
      wr({1'b1, c}, d);
      sel(1'b0, tsw_pkg::MS_CMH, 3'h0);
      wr({1'b1, c}, 8'h03);
      @(negedge ref_clk);
      master_drive_in = 1'b1;
      cco_hit(977, {1'b0, rx_in[d[7:5]], 1'b1});
      $display("connection test end");
      @(negedge ref_clk);
      resetn = 1'b0;
      @(negedge ref_clk);
      chk(serial_out_oe, 8'h00);
      resetn = 1'b1;
      rd(6'h00, tsw_pkg::CTRL_RESET);
      $display("reset test end");
      tally_and_finish;
   end
endmodule
bind tsw_switch_ctrl tsw_switch_ctrl_asserts i_tsw_switch_ctrl_asserts (.ref_clk, .resetn,
   .host_req, .host_rsp, .rx_in, .master_drive_in, .serial_out_streams, .serial_out_oe,
   .per_channel_ctrl_out);
